// >>> logic/dli_executor.sv
`timescale 1ns/1ns
module dli_executor (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_NRST,
    // received bytes from the line layer
    input wire logic I_RX_VALID,
    input wire logic [7:0] I_RX_DATA,
    input wire logic I_RX_SYNC,
    input wire logic I_RX_BREAK,
    input wire logic I_RX_ERROR,
    input wire logic I_BIT_TICK,
    // transmit bytes to the line layer
    output logic O_TX_VALID,
    output logic [7:0] O_TX_DATA,
    input wire logic I_TX_READY,
    // access layer
    output dli_pkg::dli_acc_s O_ACC,
    input wire logic I_ACC_ACK,
    input wire logic I_ACC_ERROR,
    input wire logic [31:0] I_ACC_RDATA,
    // status
    output logic O_ERROR_FLAG
);
    import dli_pkg::*;

    dli_state_e state_reg;
    logic [7:0] instr_reg;
    logic [1:0] cnt_reg;
    logic [31:0] addr_reg;
    logic [31:0] wdata_reg;
    logic [31:0] rdata_reg;
    logic [31:0] ptr_reg;
    logic [7:0] rpt_reg;
    logic first_reg;
    logic ackdata_reg;
    logic issued_reg;
    logic [GUARD_FIELD_W-1:0] gcnt_reg;
    logic err_reg;
    logic [7:0] cs_mem [CS_DEPTH];
    logic [2:0] op;
    logic [1:0] size_b;
    logic [1:0] cur_len;
    logic last_byte;
    logic [31:0] addr_next;
    logic [GUARD_FIELD_W-1:0] guard_field;
    logic tx_take;
    logic acc_done;

    function automatic logic [31:0] nbytes(input logic [1:0] sz);
        nbytes = {30'h0000_0000, sz} + 32'h0000_0001;
    endfunction

    // first state of an instruction or a repeat run after the instruction byte
    function automatic dli_state_e entry(input logic [7:0] ins);
        logic [1:0] ps;
        ps = ins[PSEL_LSB +: 2];
        unique case (ins[7:OP_LSB])
            OP_LOAD_DIRECT, OP_STORE_DIRECT: entry = ST_ADDR;
            OP_LOAD_INDIRECT: entry = (ps == PSEL_POINTER) ? ST_PTRRD : ST_ACC;
            OP_STORE_INDIRECT: entry = (ps == PSEL_POINTER) ? ST_ADDR : ST_DATA;
            OP_LOAD_CTRL_STATUS: entry = ST_CSRD;
            OP_STORE_CTRL_STATUS, OP_REPEAT: entry = ST_DATA;
            default: entry = ST_ERR;
        endcase
    endfunction

    assign op = instr_reg[7:OP_LSB];
    assign size_b = instr_reg[SIZE_B_LSB +: 2];
    assign guard_field = cs_mem[CS_CTRL][GUARD_FIELD_LSB +: GUARD_FIELD_W];
    assign tx_take = O_TX_VALID && I_TX_READY;
    assign acc_done = O_ACC.valid && I_ACC_ACK;

    always_comb begin
        if (state_reg == ST_ADDR) begin
            cur_len = instr_reg[SIZE_A_LSB +: 2];
        end else if (op == OP_LOAD_CTRL_STATUS ||
                op == OP_STORE_CTRL_STATUS) begin
            cur_len = 2'h0;
        end else begin
            cur_len = size_b;
        end
    end

    assign last_byte = (cnt_reg == cur_len);

    // least significant byte arrives first
    always_comb begin
        addr_next = (cnt_reg == 2'h0) ? 32'h0000_0000 : addr_reg;
        addr_next[{cnt_reg, 3'h0} +: 8] = I_RX_DATA;
    end

    // sequencing
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            state_reg <= ST_IDLE;
            instr_reg <= 8'h00;
            first_reg <= 1'b1;
            ackdata_reg <= 1'b0;
        end else if (I_RX_BREAK) begin
            state_reg <= ST_IDLE;
            first_reg <= 1'b1;
        end else if ((I_RX_ERROR || (acc_done && I_ACC_ERROR)) &&
                state_reg != ST_ERR) begin
            state_reg <= ST_ERR;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (I_RX_SYNC) begin
                        state_reg <= ST_INSTR;
                    end
                end
                ST_INSTR: begin
                    if (I_RX_VALID) begin
                        instr_reg <= I_RX_DATA;
                        first_reg <= 1'b1;
                        state_reg <= entry(I_RX_DATA);
                    end
                end
                ST_ADDR: begin
                    if (I_RX_VALID && last_byte) begin
                        if (op == OP_LOAD_DIRECT) begin
                            state_reg <= ST_ACC;
                        end else begin
                            ackdata_reg <= (op == OP_STORE_DIRECT);
                            state_reg <= ST_ACK;
                        end
                    end
                end
                ST_DATA: begin
                    if (I_RX_VALID && last_byte) begin
                        if (op == OP_STORE_DIRECT ||
                                op == OP_STORE_INDIRECT) begin
                            state_reg <= ST_ACC;
                        end else begin
                            state_reg <= ST_FIN;
                        end
                    end
                end
                ST_ACC: begin
                    if (acc_done) begin
                        if (O_ACC.write) begin
                            ackdata_reg <= 1'b0;
                            state_reg <= ST_ACK;
                        end else if (first_reg || op == OP_LOAD_DIRECT) begin
                            state_reg <= ST_GUARD;
                        end else begin
                            state_reg <= ST_SEND;
                        end
                    end
                end
                ST_PTRRD: begin
                    state_reg <= first_reg ? ST_GUARD : ST_SEND;
                end
                ST_CSRD: begin
                    state_reg <= ST_GUARD;
                end
                ST_GUARD: begin
                    if (I_BIT_TICK && gcnt_reg == guard_field) begin
                        state_reg <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (tx_take && last_byte) begin
                        state_reg <= ST_FIN;
                    end
                end
                ST_ACK: begin
                    if (tx_take) begin
                        state_reg <= ackdata_reg ? ST_DATA : ST_FIN;
                        ackdata_reg <= 1'b0;
                    end
                end
                ST_FIN: begin
                    if (rpt_reg != 8'h00 && op != OP_REPEAT) begin
                        first_reg <= 1'b0;
                        state_reg <= entry(instr_reg);
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_ERR: begin
                    state_reg <= ST_ERR;
                end
            endcase
        end
    end

    // repeat counter
    always_ff @(posedge I_CLK) begin
        if (!I_NRST || I_RX_BREAK) begin
            rpt_reg <= 8'h00;
        end else if (state_reg == ST_DATA && op == OP_REPEAT &&
                I_RX_VALID && cnt_reg == 2'h0) begin
            rpt_reg <= I_RX_DATA;
        end else if (state_reg == ST_FIN && op != OP_REPEAT &&
                rpt_reg != 8'h00) begin
            rpt_reg <= rpt_reg - 8'h01;
        end
    end

    // byte index within the current phase
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            cnt_reg <= 2'h0;
        end else if (state_reg == ST_ADDR || state_reg == ST_DATA) begin
            if (I_RX_VALID) begin
                cnt_reg <= last_byte ? 2'h0 : cnt_reg + 2'h1;
            end
        end else if (state_reg == ST_SEND) begin
            if (tx_take) begin
                cnt_reg <= last_byte ? 2'h0 : cnt_reg + 2'h1;
            end
        end else begin
            cnt_reg <= 2'h0;
        end
    end

    // operand capture
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            addr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
        end else if (I_RX_VALID && state_reg == ST_ADDR) begin
            addr_reg <= addr_next;
        end else if (I_RX_VALID && state_reg == ST_DATA) begin
            wdata_reg <= (cnt_reg == 2'h0) ? 32'h0000_0000 : wdata_reg;
            wdata_reg[{cnt_reg, 3'h0} +: 8] <= I_RX_DATA;
        end
    end

    // address pointer
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            ptr_reg <= 32'h0000_0000;
        end else if (state_reg == ST_ADDR && op == OP_STORE_INDIRECT &&
                I_RX_VALID && last_byte) begin
            ptr_reg <= addr_next;
        end else if (acc_done && !I_ACC_ERROR &&
                (op == OP_LOAD_INDIRECT || op == OP_STORE_INDIRECT) &&
                instr_reg[PSEL_LSB +: 2] == PSEL_POST_INC) begin
            ptr_reg <= ptr_reg + nbytes(size_b);
        end
    end

    // read data for the response
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            rdata_reg <= 32'h0000_0000;
        end else if (state_reg == ST_ACC && acc_done) begin
            rdata_reg <= I_ACC_RDATA;
        end else if (state_reg == ST_PTRRD) begin
            rdata_reg <= ptr_reg;
        end else if (state_reg == ST_CSRD) begin
            rdata_reg <= {24'h00_0000, (instr_reg[CS_ADDR_W-1:0] == CS_STATUS) ?
                {7'h00, err_reg} : cs_mem[instr_reg[CS_ADDR_W-1:0]]};
        end
    end

    // guard time idle bit counter
    always_ff @(posedge I_CLK) begin
        if (!I_NRST || state_reg != ST_GUARD) begin
            gcnt_reg <= '0;
        end else if (I_BIT_TICK) begin
            gcnt_reg <= gcnt_reg + 3'h1;
        end
    end

    // access layer request, held until acknowledged
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            O_ACC <= '0;
            issued_reg <= 1'b0;
        end else if (I_RX_BREAK || state_reg != ST_ACC) begin
            O_ACC.valid <= 1'b0;
            issued_reg <= 1'b0;
        end else if (!issued_reg) begin
            O_ACC.valid <= 1'b1;
            O_ACC.write <= (op == OP_STORE_DIRECT || op == OP_STORE_INDIRECT);
            O_ACC.size <= size_b;
            O_ACC.addr <= (op == OP_LOAD_DIRECT || op == OP_STORE_DIRECT) ?
                addr_reg : ptr_reg;
            O_ACC.wdata <= wdata_reg;
            issued_reg <= 1'b1;
        end else if (I_ACC_ACK) begin
            O_ACC.valid <= 1'b0;
        end
    end

    // transmit side: response bytes and acknowledges
    always_ff @(posedge I_CLK) begin
        if (!I_NRST || I_RX_BREAK) begin
            O_TX_VALID <= 1'b0;
            O_TX_DATA <= 8'h00;
        end else if (O_TX_VALID) begin
            if (I_TX_READY) begin
                O_TX_VALID <= 1'b0;
            end
        end else if (state_reg == ST_SEND) begin
            O_TX_VALID <= 1'b1;
            O_TX_DATA <= rdata_reg[{cnt_reg, 3'h0} +: 8];
        end else if (state_reg == ST_ACK) begin
            O_TX_VALID <= 1'b1;
            O_TX_DATA <= ACK_BYTE;
        end
    end

    // control/status space
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            for (int i = 0; i < CS_DEPTH; i++) begin
                cs_mem[i] <= CS_RESET;
            end
        end else if (state_reg == ST_DATA && op == OP_STORE_CTRL_STATUS &&
                I_RX_VALID) begin
            cs_mem[instr_reg[CS_ADDR_W-1:0]] <= I_RX_DATA;
        end
    end

    // sticky error flag; a new error wins over the clear
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            err_reg <= 1'b0;
        end else if ((I_RX_ERROR || (acc_done && I_ACC_ERROR)) &&
                !I_RX_BREAK) begin
            err_reg <= 1'b1;
        end else if (state_reg == ST_DATA && op == OP_STORE_CTRL_STATUS &&
                I_RX_VALID && instr_reg[CS_ADDR_W-1:0] == CS_STATUS) begin
            err_reg <= 1'b0;
        end
    end

    assign O_ERROR_FLAG = err_reg;
endmodule

// >>> logic/dli_pkg.sv
// Contract
// - direct load: instruction, address bytes by size A, data out by size B
// - direct load data goes out only after guard idle bits
// - repeated direct load takes a fresh address each time, never increments
// - direct store: address, ACK, data, second ACK
// - indirect load reads at pointer, optional post-increment, or returns pointer
// - indirect store with pointer select 2 writes pointer, then ACK
// - pointer select 0 keeps pointer, 1 advances it by data size
// - indirect store data: ACK only after the bus write completes
// - control/status load returns one internal byte after guard time
// - control/status store writes one whole byte, sends no response
// - repeat loads counter; sync and instruction only for first run
// - counter up to 255; instruction runs counter plus one times
// - only a BREAK ends an ongoing repeat
// - repeated indirect store takes data bytes only, ACK after each
// - repeated indirect load streams; guard only before first block
// - bus transfer goes to access layer; debugger tolerates its delay
// - guard idle bit count comes from a control register field
// - after any error ignore everything except BREAK
package dli_pkg;
    // instruction layout
    localparam int OP_LSB = 5;
    localparam int SIZE_A_LSB = 2;
    localparam int SIZE_B_LSB = 0;
    localparam int PSEL_LSB = 2;
    localparam int CS_ADDR_W = 4;
    // opcodes
    localparam logic [2:0] OP_LOAD_DIRECT = 3'h0;
    localparam logic [2:0] OP_LOAD_INDIRECT = 3'h1;
    localparam logic [2:0] OP_STORE_DIRECT = 3'h2;
    localparam logic [2:0] OP_STORE_INDIRECT = 3'h3;
    localparam logic [2:0] OP_LOAD_CTRL_STATUS = 3'h4;
    localparam logic [2:0] OP_REPEAT = 3'h5;
    localparam logic [2:0] OP_STORE_CTRL_STATUS = 3'h6;
    // pointer_select codes
    localparam logic [1:0] PSEL_PLAIN = 2'h0;
    localparam logic [1:0] PSEL_POST_INC = 2'h1;
    localparam logic [1:0] PSEL_POINTER = 2'h2;
    // response and control/status space
    localparam logic [7:0] ACK_BYTE = 8'h40;
    localparam int CS_DEPTH = 16;
    localparam logic [3:0] CS_STATUS = 4'h0;
    localparam logic [3:0] CS_CTRL = 4'h2;
    localparam int GUARD_FIELD_LSB = 0;
    localparam int GUARD_FIELD_W = 3;
    localparam logic [7:0] CS_RESET = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE, ST_INSTR, ST_ADDR, ST_DATA, ST_ACC, ST_PTRRD,
        ST_CSRD, ST_GUARD, ST_SEND, ST_ACK, ST_FIN, ST_ERR
    } dli_state_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dli_acc_s;
endpackage

// >>> testbench/dli_bus_model.sv
`timescale 1ns/1ns
module dli_bus_model (
    // access layer side
    input wire logic i_clk,
    input dli_pkg::dli_acc_s i_acc,
    input wire logic i_slow,
    output logic o_ack,
    output logic [31:0] o_rdata
);
    import dli_pkg::*;
    logic [7:0] mem_reg [int];
    int wait_cnt = 0;
    initial o_ack = 1'b0;
    initial o_rdata = 32'h0000_0000;
    // read data only meaningful with ack, stale bytes toggle
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_acc.valid && !o_ack) begin
            if (wait_cnt < (i_slow ? 6 : 0)) begin
                wait_cnt++;
            end else begin
                wait_cnt = 0;
                o_ack <= 1'b1;
                for (int i = 0; i <= int'(i_acc.size); i++) begin
                    if (i_acc.write) begin
                        mem_reg[int'(i_acc.addr) + i] = i_acc.wdata[8*i +: 8];
                    end else if (mem_reg.exists(int'(i_acc.addr) + i)) begin
                        o_rdata[8*i +: 8] <= mem_reg[int'(i_acc.addr) + i];
                    end
                end
            end
        end
    end
endmodule

// >>> testbench/dli_executor_checker.sv
`timescale 1ns/1ns
module dli_executor_checker (
    // watched ports
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic I_RX_VALID,
    input wire logic I_RX_BREAK,
    input wire logic I_RX_ERROR,
    input wire logic I_TX_READY,
    input wire logic O_TX_VALID,
    input wire logic [7:0] O_TX_DATA,
    input dli_pkg::dli_acc_s O_ACC,
    input wire logic I_ACC_ACK,
    input wire logic I_ACC_ERROR,
    input wire logic O_ERROR_FLAG
);
    import dli_pkg::*;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    chk_tx_byte_hold: assert property (
        O_TX_VALID && !I_TX_READY && !I_RX_BREAK
        |=> O_TX_VALID && $stable(O_TX_DATA))
        else $error("tx byte changed before taken");
    chk_tx_gap: assert property (
        O_TX_VALID && I_TX_READY |=> !O_TX_VALID)
        else $error("tx valid not dropped after take");
    chk_acc_hold: assert property (
        O_ACC.valid && !I_ACC_ACK && !I_RX_BREAK |=> $stable(O_ACC))
        else $error("access request changed while pending");
    chk_acc_done: assert property (
        O_ACC.valid && I_ACC_ACK |=> !O_ACC.valid)
        else $error("access request held after ack");
    chk_write_ack: assert property (
        O_ACC.valid && O_ACC.write && I_ACC_ACK && !I_ACC_ERROR
        |-> ##[1:3] O_TX_VALID && O_TX_DATA == ACK_BYTE)
        else $error("no ack byte after bus write");
    chk_err_set: assert property (
        (I_RX_ERROR || O_ACC.valid && I_ACC_ACK && I_ACC_ERROR) &&
        !I_RX_BREAK |=> O_ERROR_FLAG)
        else $error("error flag not set");
    chk_err_quiet: assert property (
        I_RX_ERROR && !O_TX_VALID && !O_ACC.valid ##1 !I_RX_BREAK [*8]
        |-> !O_TX_VALID && !O_ACC.valid)
        else $error("activity in error state");
    chk_flag_sticky: assert property (
        O_ERROR_FLAG && !I_RX_VALID |=> O_ERROR_FLAG)
        else $error("error flag cleared without store");
    chk_break_stop: assert property (
        I_RX_BREAK |-> ##[1:2] !O_TX_VALID)
        else $error("transmit continues after break");
endmodule

bind dli_executor dli_executor_checker i_chk (
    .I_CLK(I_CLK), .I_NRST(I_NRST), .I_RX_VALID(I_RX_VALID),
    .I_RX_BREAK(I_RX_BREAK), .I_RX_ERROR(I_RX_ERROR),
    .I_TX_READY(I_TX_READY), .O_TX_VALID(O_TX_VALID),
    .O_TX_DATA(O_TX_DATA), .O_ACC(O_ACC), .I_ACC_ACK(I_ACC_ACK),
    .I_ACC_ERROR(I_ACC_ERROR), .O_ERROR_FLAG(O_ERROR_FLAG)
);

// >>> testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
    import dli_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, rx_valid = 1'b0, rx_sync = 1'b0;
    logic rx_break = 1'b0, rx_error = 1'b0, tick = 1'b0, tx_ready = 1'b0;
    logic slow = 1'b0, bus_bad = 1'b0, tick_en = 1'b1;
    logic [7:0] rx_data = 8'h00, cs_val;
    logic tx_valid, err_flag, acc_ack, acc_err;
    logic [7:0] tx_data;
    logic [31:0] rdata, a, d, p;
    dli_acc_s acc;
    logic [7:0] exp_q [$];
    int num_errors = 0, total_checks = 0, cyc = 0, r;
    assign acc_err = acc_ack & bus_bad;
    always #4 clk = ~clk;
    dli_executor i_dut (.I_CLK(clk), .I_NRST(nrst), .I_RX_VALID(rx_valid),
        .I_RX_DATA(rx_data), .I_RX_SYNC(rx_sync), .I_RX_BREAK(rx_break),
        .I_RX_ERROR(rx_error), .I_BIT_TICK(tick), .O_TX_VALID(tx_valid),
        .O_TX_DATA(tx_data), .I_TX_READY(tx_ready), .O_ACC(acc),
        .I_ACC_ACK(acc_ack), .I_ACC_ERROR(acc_err), .I_ACC_RDATA(rdata),
        .O_ERROR_FLAG(err_flag));
    dli_bus_model i_bus (.i_clk(clk), .i_acc(acc), .i_slow(slow),
        .o_ack(acc_ack), .o_rdata(rdata));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bit ticks and a stalling far side
    always @(negedge clk) begin
        cyc++;
        tick <= tick_en && (cyc % 4 == 0);
        tx_ready <= 1'($urandom % 2);
    end
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            if (exp_q.size() == 0) begin
                chk(tx_data, 8'hxx);
            end else begin
                chk(tx_data, exp_q.pop_front());
            end
        end
    end
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic rx(input logic [7:0] b);
        @(negedge clk);
        rx_data = b;
        rx_valid = 1'b1;
        @(negedge clk);
        rx_valid = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic instr(input logic [7:0] b);
        pulse(rx_sync);
        rx(b);
    endtask
    // operands travel least significant byte first
    task automatic rxn(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) rx(v[8*i +: 8]);
    endtask
    task automatic expn(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) exp_q.push_back(v[8*i +: 8]);
    endtask
    task automatic drain;
        int n;
        n = 0;
        while ((exp_q.size() != 0 || tx_valid) && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n == 3000) chk(8'(exp_q.size() + int'(tx_valid)), 8'h00);
        repeat (4) @(negedge clk);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
    initial begin
        r = $urandom(32'he170_923e);
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        cs_val = 8'($urandom);
        a = {16'h0000, 1'b1, 15'($urandom)};
        d = $urandom;
        p = {16'h0000, 1'b0, 15'($urandom)} & 32'h0000_7ff0;
        instr(8'hc5); rx(cs_val);
        instr(8'hc2); rx(8'h01);
        tick_en = 1'b0;
        exp_q.push_back(cs_val);
        instr(8'h85); repeat (40) @(negedge clk);
        chk(8'(tx_valid), 8'h00);
        tick_en = 1'b1; drain;
        $display("test ctrl_status finished");
        exp_q.push_back(ACK_BYTE);
        instr(8'h47); rxn(a, 2); drain;
        exp_q.push_back(ACK_BYTE);
        rxn(d, 4); drain;
        expn(d, 4); instr(8'h07); rxn(a, 2); drain;
        $display("test direct finished");
        exp_q.push_back(ACK_BYTE);
        instr(8'h6b); rxn(p, 3); drain;
        instr(8'ha0); rx(8'h02); instr(8'h64);
        for (int i = 0; i < 3; i++) begin
            exp_q.push_back(ACK_BYTE);
            rx(d[8*i +: 8]); drain;
        end
        exp_q.push_back(ACK_BYTE);
        instr(8'h60); rx(8'h3c); drain;
        expn(p + 3, 4); instr(8'h2b); drain;
        exp_q.push_back(ACK_BYTE);
        instr(8'h6b); rxn(p, 3); drain;
        expn({8'h3c, d[23:0]}, 4);
        instr(8'ha0); rx(8'h03); instr(8'h24); drain;
        exp_q.push_back(cs_val);
        instr(8'ha0); rx(8'h00); instr(8'h85); drain;
        $display("test indirect finished");
        slow = 1'b1;
        expn(d, 4);
        instr(8'ha0); rx(8'h01); instr(8'h07);
        rxn(a, 2); drain;
        expn({8'h3c, d[23:0]}, 4);
        rxn(p, 2); drain;
        slow = 1'b0;
        expn(d, 4);
        instr(8'ha0); rx(8'h05); instr(8'h07); rxn(a, 2); drain;
        exp_q.push_back(cs_val);
        pulse(rx_break); instr(8'h85); drain;
        $display("test repeat finished");
        pulse(rx_error); repeat (2) @(negedge clk);
        chk(8'(err_flag), 8'h01);
        instr(8'h85); repeat (30) @(negedge clk);
        chk(8'(tx_valid), 8'h00);
        exp_q.push_back(8'h01);
        pulse(rx_break); instr(8'h80); drain;
        exp_q.push_back(8'h00);
        instr(8'hc0); rx(8'h00); instr(8'h80); drain;
        bus_bad = 1'b1;
        exp_q.push_back(ACK_BYTE);
        instr(8'h40); rx(8'h10); drain; rx(8'h55); drain;
        chk(8'(err_flag), 8'h01);
        bus_bad = 1'b0;
        pulse(rx_break);
        instr(8'he0); instr(8'h85); repeat (30) @(negedge clk);
        chk(8'(tx_valid), 8'h00);
        pulse(rx_break);
        $display("test error finished");
        end_of_test();
    end
endmodule
